/* hdl/rrt_rate_trim.sv */
// RTC rate trim: analog trim, eight-second digital rate word, test mux
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "rrt_map.svh"

module rrt_rate_trim (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  input  wire logic                rtc_tick_source,
  output rrt_pkg::rrt_trim_t       analog_load_trim,
  output logic                     second_tick,
  output logic                     test_mux_pin
);
  import rrt_pkg::*;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] wb_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Cycle count at which second k of the span ends: floor((k+1)*W/8)
  function automatic rrt_rate_t sec_end(
    input rrt_sec_idx_t k,
    input rrt_rate_t    w
  );
    logic [21:0] prod;
    prod = 22'({1'b0, k} + 4'h1) * 22'(w);
    return prod[21:3];
  endfunction

  // Register word as software reads it, reserved bits zero;
  // unmapped offsets read as zero
  function automatic logic [31:0] reg_word(
    input logic [7:0]  adr,
    input rrt_trim_t   trim,
    input rrt_coarse_t coarse,
    input rrt_frac_t   frac,
    input rrt_test_mux_select_t   test_mux_select,
    input logic [31:0] secs
  );
    logic [31:0] res;
    res = 32'h00000000;
    unique case (adr)
      `RRT_OFS_TRIM:    res = {25'h0000000, trim};
      `RRT_OFS_COARSE:  res = {15'h0000, coarse};
      `RRT_OFS_FRAC:    res = {30'h00000000, frac};
      `RRT_OFS_TEST_MUX_SELECT:    res = {27'h0000000, test_mux_select};
      `RRT_OFS_SECONDS: res = secs;
      default:          res = 32'h00000000;
    endcase
    return res;
  endfunction

  // Bus slave state
  rrt_trim_t   trim_r,   trim_nxt;
  rrt_coarse_t coarse_r, coarse_nxt;
  rrt_frac_t   frac_r,   frac_nxt;
  rrt_test_mux_select_t   test_mux_select_r,   test_mux_select_nxt;
  logic        ack_r,    ack_nxt;
  logic [31:0] rdat_r,   rdat_nxt;
  logic [31:0] wr_word;

  // Time base state
  logic         osc_prev_r, osc_prev_nxt;
  rrt_rate_t    cnt_r,      cnt_nxt;
  rrt_sec_idx_t idx_r,      idx_nxt;
  rrt_rate_t    rate_act_r, rate_act_nxt;
  logic [31:0]  secs_r,     secs_nxt;
  logic         pul1_r,     pul1_nxt;
  logic         pul4_r,     pul4_nxt;
  logic         tick_r,     tick_nxt;
  logic         pin_r,      pin_nxt;
  rrt_rate_t    rate_word;
  rrt_rate_t    cnt_inc;
  logic         osc_edge;
  logic         sec_done;

  assign rate_word = {coarse_r, frac_r};
  assign osc_edge  = rtc_tick_source & ~osc_prev_r;
  assign cnt_inc   = cnt_r + 19'h00001;
  // A rate word of zero only matches after the count wraps, so software must avoid it
  assign sec_done  = osc_edge && (cnt_inc == sec_end(idx_r, rate_act_r));

  // Bus answer: ack one cycle after the request is taken and low the cycle after,
  // so a strobe held high is answered every other cycle
  always_comb begin
    ack_nxt  = cyc_i & stb_i & ~ack_r;
    rdat_nxt = rdat_r;
    // Read data is captured in the request cycle so it is stable with ack
    if (cyc_i && stb_i && !ack_r) begin
      rdat_nxt = reg_word(adr_i, trim_r, coarse_r, frac_r, test_mux_select_r, secs_r);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // Register file: a write lands at the edge where ack is seen; unmapped and
  // read-only offsets drop it
  // Writes with no byte lane enabled leave the register as it was
  always_comb begin
    trim_nxt   = trim_r;
    coarse_nxt = coarse_r;
    frac_nxt   = frac_r;
    test_mux_select_nxt   = test_mux_select_r;
    wr_word    = 32'h00000000;
    if (cyc_i && stb_i && we_i && ack_r) begin
      unique case (adr_i)
        `RRT_OFS_TRIM: begin
          wr_word  = wb_merge({25'h0000000, trim_r}, dat_i, sel_i);
          trim_nxt = wr_word[6:0];
        end
        `RRT_OFS_COARSE: begin
          wr_word    = wb_merge({15'h0000, coarse_r}, dat_i, sel_i);
          coarse_nxt = wr_word[16:0];
        end
        `RRT_OFS_FRAC: begin
          wr_word  = wb_merge({30'h00000000, frac_r}, dat_i, sel_i);
          frac_nxt = wr_word[1:0];
        end
        `RRT_OFS_TEST_MUX_SELECT: begin
          wr_word  = wb_merge({27'h0000000, test_mux_select_r}, dat_i, sel_i);
          test_mux_select_nxt = wr_word[4:0];
        end
        default: begin
          wr_word = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trim_r   <= `RRT_TRIM_RST;
      coarse_r <= `RRT_COARSE_RST;
      frac_r   <= `RRT_FRAC_RST;
      test_mux_select_r   <= `RRT_TEST_MUX_SELECT_RST;
    end else begin
      trim_r   <= trim_nxt;
      coarse_r <= coarse_nxt;
      frac_r   <= frac_nxt;
      test_mux_select_r   <= test_mux_select_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;
  // Trim goes straight to the load array: 00 least load, 3F most load
  assign analog_load_trim = trim_r;

  // Edge detector: resets high so a source already high at release is not
  // counted as a fresh edge
  always_comb begin
    osc_prev_nxt = rtc_tick_source;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_prev_r <= 1'b1;
    end else begin
      osc_prev_r <= osc_prev_nxt;
    end
  end

  // Span counter: the rate word counts oscillator cycles over eight seconds.
  // The span's word is latched only at a span boundary, so a write never
  // shortens or stretches a second already in progress.
  always_comb begin
    cnt_nxt      = cnt_r;
    idx_nxt      = idx_r;
    rate_act_nxt = rate_act_r;
    if (osc_edge) begin
      cnt_nxt = cnt_inc;
    end
    if (sec_done) begin
      idx_nxt = idx_r + 3'h1;
      // Rounding remainders of the earlier seconds all land by the last one
      if (idx_r == `RRT_SPAN_SECONDS) begin
        cnt_nxt      = 19'h00000;
        rate_act_nxt = rate_word;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r      <= 19'h00000;
      idx_r      <= 3'h0;
      rate_act_r <= {`RRT_COARSE_RST, `RRT_FRAC_RST};
    end else begin
      cnt_r      <= cnt_nxt;
      idx_r      <= idx_nxt;
      rate_act_r <= rate_act_nxt;
    end
  end

  // Seconds count and one-clock tick; each second may differ by one cycle,
  // but eight of them always add up to the span word
  always_comb begin
    secs_nxt = secs_r;
    tick_nxt = 1'b0;
    if (sec_done) begin
      tick_nxt = 1'b1;
      secs_nxt = secs_r + 32'h00000001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      secs_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else begin
      secs_r <= secs_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Test pulses stand for one oscillator period, long enough for a counter;
  // the four-second pulse marks seconds 3 and 7 of each span
  always_comb begin
    pul1_nxt = pul1_r;
    pul4_nxt = pul4_r;
    if (osc_edge) begin
      pul1_nxt = sec_done;
      pul4_nxt = sec_done && (idx_r[1:0] == 2'b11);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pul1_r <= 1'b0;
      pul4_r <= 1'b0;
    end else begin
      pul1_r <= pul1_nxt;
      pul4_r <= pul4_nxt;
    end
  end

  assign second_tick = tick_r;

  // Test pin source select; unlisted codes hold the pin low
  // The raw clock passes through a flop, so the pin lags the source by one clock
  always_comb begin
    unique case (test_mux_select_r)
      `RRT_TEST_MUX_SELECT_SEC1: pin_nxt = pul1_r;
      `RRT_TEST_MUX_SELECT_SEC4: pin_nxt = pul4_r;
      `RRT_TEST_MUX_SELECT_RAW:  pin_nxt = rtc_tick_source;
      default:        pin_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign test_mux_pin = pin_r;
endmodule

/* common/rrt_map.svh */
// Register offsets, field widths and reset values of the rate-trim block
`ifndef RRT_MAP_SVH
`define RRT_MAP_SVH

`define RRT_OFS_TRIM      8'h00
`define RRT_OFS_COARSE    8'h04
`define RRT_OFS_FRAC      8'h08
`define RRT_OFS_TEST_MUX_SELECT      8'h0C
`define RRT_OFS_SECONDS   8'h10

`define RRT_TRIM_W        7
`define RRT_COARSE_W      17
`define RRT_FRAC_W        2
`define RRT_TEST_MUX_SELECT_W        5
`define RRT_RATE_W        19

`define RRT_TRIM_MIN      7'h00
`define RRT_TRIM_MAX      7'h3F
`define RRT_TRIM_RST      7'h00
`define RRT_COARSE_RST    17'h10000
`define RRT_FRAC_RST      2'h0
`define RRT_TEST_MUX_SELECT_RST      5'h00

`define RRT_TEST_MUX_SELECT_SEC1     5'h10
`define RRT_TEST_MUX_SELECT_SEC4     5'h11
`define RRT_TEST_MUX_SELECT_RAW      5'h1D

`define RRT_SPAN_SECONDS  3'h7
`define RRT_OSC_PER_SEC   17'h08000

`endif

/* common/rrt_pkg.sv */
// Types shared by the rate-trim block
package rrt_pkg;
  typedef logic [6:0]  rrt_trim_t;
  typedef logic [16:0] rrt_coarse_t;
  typedef logic [1:0]  rrt_frac_t;
  typedef logic [4:0]  rrt_test_mux_select_t;
  typedef logic [18:0] rrt_rate_t;
  typedef logic [2:0]  rrt_sec_idx_t;
endpackage

/* test/rrt_props.sv */
// Checker on the rate-trim ports
`timescale 1ns/1ps
module rrt_props (
  input logic               clock,
  input logic               rst,
  input logic               cyc_i,
  input logic               stb_i,
  input logic               we_i,
  input logic [7:0]         adr_i,
  input logic [3:0]         sel_i,
  input logic [31:0]        dat_i,
  input logic [31:0]        dat_o,
  input logic               ack_o,
  input logic               rtc_tick_source,
  input rrt_pkg::rrt_trim_t analog_load_trim,
  input logic               second_tick,
  input logic               test_mux_pin
);
  import rrt_pkg::*;
  rrt_test_mux_select_t sel_r;
  logic      wr;
  logic      sec_sel;
  // Shadow of the test select, since only ports are visible here
  assign wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
  assign sec_sel = (sel_r == 5'h10);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_r <= 5'h00;
    end else if (wr && adr_i == 8'h0C) begin
      sel_r <= dat_i[4:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_trim; wr && adr_i == 8'h00; endsequence
  a_ack_due: assert property (s_req |=> ack_o) else $error("ack late");
  a_ack_once: assert property (ack_o |=> !ack_o) else $error("ack long");
  a_ack_cause: assert property (ack_o |-> $past(stb_i)) else $error("stray ack");
  a_trim_load: assert property (s_trim |=> analog_load_trim == $past(dat_i[6:0]))
    else $error("trim load");
  a_trim_hold: assert property (!wr |=> $stable(analog_load_trim))
    else $error("trim moved");
  a_raw_pin: assert property (sel_r == 5'h1D && $past(sel_r) == 5'h1D |->
    test_mux_pin == $past(rtc_tick_source)) else $error("raw pin");
  a_pin_off: assert property (sel_r < 5'h10 && $past(sel_r) == sel_r |-> !test_mux_pin)
    else $error("pin on");
  a_tick_once: assert property (second_tick |=> !second_tick) else $error("tick long");
  a_sec_pulse: assert property (sec_sel && $past(sec_sel) && $rose(test_mux_pin) |->
    $past(second_tick)) else $error("pulse without tick");
endmodule
bind rrt_rate_trim rrt_props i_props (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .rtc_tick_source, .analog_load_trim, .second_tick, .test_mux_pin);

/* test/rrt_osc_model.sv */
// Stand-in oscillator on the tick source
`timescale 1ns/1ps
module rrt_osc_model (
  input  wire logic clock,
  input  wire logic rst,
  output logic      osc
);
  // Fastest rate the edge detector can count, one rising edge every two clocks,
  // so the first second after reset ends inside a short run
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      osc <= 1'b0;
    end else begin
      osc <= ~osc;
    end
  end
endmodule

/* test/testbench.sv */
// Bench for registers, trim output and test pin
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'h0, rst = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [6:0]  analog_load_trim;
  logic        ack_o, rtc_tick_source, second_tick, test_mux_pin, p;
  int          num_errors = 0, checked = 0;
  int          osc_edges = 0, waited = 0;
  logic        osc_seen = 1'h1;
  always #2 clock = ~clock;
  rrt_rate_trim i_dut (.clock, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .rtc_tick_source, .analog_load_trim, .second_tick, .test_mux_pin);
  rrt_osc_model i_osc (.clock, .rst, .osc(rtc_tick_source));
  // Reference count of oscillator rising edges since the last reset
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_seen  <= 1'h1;
      osc_edges <= 0;
    end else begin
      osc_seen <= rtc_tick_source;
      if (rtc_tick_source && !osc_seen) begin
        osc_edges <= osc_edges + 1;
      end
    end
  end
  task automatic results;
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int n = 0;
    @(posedge clock);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, s};
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    chk("ack", {31'h0, ack_o}, 32'h1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic wrc(logic [7:0] a, logic [31:0] d, logic [3:0] s, logic [31:0] e);
    bus(1'h1, a, d, s);
    bus(1'h0, a, 32'h0, 4'h0);
    chk("readback", q, e);
  endtask
  // No lanes enabled, so these writes must leave the defaults alone
  task automatic rr;
    wrc(8'h00, 32'h7F, 4'h0, 32'h0);
    wrc(8'h04, 32'h0, 4'h0, 32'h10000);
    wrc(8'h08, 32'h3, 4'h0, 32'h0);
    wrc(8'h10, 32'h0, 4'h0, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    rr;
    wrc(8'h00, 32'h3F, 4'h1, 32'h3F);
    chk("trim", {25'h0, analog_load_trim}, 32'h3F);
    wrc(8'h00, 32'h80, 4'h1, 32'h0);
    chk("trim", {25'h0, analog_load_trim}, 32'h0);
    // Coarse stays nonzero, so the rate word is never all zero
    wrc(8'h04, 32'hFFFFFFAB, 4'h1, 32'h100AB);
    wrc(8'h08, 32'hFFFFFFFF, 4'hF, 32'h3);
    // A +3.8 ppm shift rounds to rate word 262143: coarse 0FFFF, fraction 3
    wrc(8'h04, 32'h0000FFFF, 4'h7, 32'h0FFFF);
    wrc(8'h0C, 32'h10, 4'h1, 32'h10);
    wrc(8'h0C, 32'h11, 4'h1, 32'h11);
    wrc(8'h0C, 32'h05, 4'h1, 32'h05);
    wrc(8'h0C, 32'h1D, 4'h1, 32'h1D);
    for (int i = 0; i < 40; i++) begin
      p = rtc_tick_source;
      @(posedge clock);
      chk("raw", {31'h0, test_mux_pin}, {31'h0, p});
    end
    wrc(8'h0C, 32'h10, 4'h1, 32'h10);
    // First second after reset runs on the reset word
    while (second_tick !== 1'h1 && waited < 70000) begin
      @(posedge clock);
      waited++;
    end
    chk("osc edges per second", osc_edges, 32'h00008000);
    @(posedge clock);
    chk("second pulse", {31'h0, test_mux_pin}, 32'h1);
    repeat (2) @(posedge clock);
    chk("second pulse end", {31'h0, test_mux_pin}, 32'h0);
    wrc(8'h10, 32'h0, 4'h0, 32'h1);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    rr;
    results;
  end
  initial begin
    // The first second takes about 65600 clocks
    #360000;
    num_errors++;
    results;
  end
endmodule
